// ==== inc/amst_pkg.sv ====
// Shared constants and types for the asynchronous memory strobe timing block
package amst_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 21;
    localparam int BANK_W = 2;
    localparam int DATA_W = 16;
    localparam int CS_W = 4;
    localparam int CS_SEL_W = 2;
    localparam int PHASE_W = 8;
    localparam int WAIT_LIMIT_W = 8;
    localparam int WAIT_UNIT_W = 9;
    localparam int UNIT_CNT_W = 5;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAIT_RELEASE_NS = 40;
    localparam int WAIT_RELEASE_CYCLES = (WAIT_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;
    localparam int RELEASE_LEFT_CYCLES = WAIT_RELEASE_CYCLES - SYNC_STAGES;
    localparam int WAIT_UNIT_CYCLES = 16;
    localparam int MAX_WAIT_UNITS = 256;

    // ------------------------------------------------------------
    // Reset and idle values
    // ------------------------------------------------------------
    localparam logic [CS_W-1:0] CS_IDLE = 4'hF;
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;
    localparam logic [BANK_W-1:0] BANK_RESET = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [CS_W-1:0] CS_ONE_HOT_BASE = 4'h1;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b010,
        ST_EXTEND = 3'b011,
        ST_RELEASE = 3'b100,
        ST_HOLD = 3'b101,
        ST_TURN = 3'b110
    } amst_state_t;

endpackage

// ==== design/amst_phase_counter.sv ====
// Loadable down counter that flags the last cycle of a phase
`timescale 1ns/1ps
module amst_phase_counter #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    output logic last
);
    logic [WIDTH-1:0] count_q;

    // ------------------------------------------------------------
    // Count down, hold at zero
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= loadValue;
        end else if (count_q != '0) begin
            count_q <= count_q - WIDTH'(1);
        end
    end

    assign last = (count_q == WIDTH'(1));
endmodule

// ==== design/amst_strobe_timing.sv ====
// Strobe sequencer for asynchronous SRAM and NOR flash accesses
`timescale 1ns/1ps
module amst_strobe_timing
#(
    parameter int PW = amst_pkg::PHASE_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [amst_pkg::ADDR_W-1:0] reqAddress,
    input wire logic [amst_pkg::BANK_W-1:0] reqBank,
    input wire logic [amst_pkg::CS_SEL_W-1:0] reqChip,
    input wire logic [amst_pkg::DATA_W-1:0] reqWriteData,
    output logic reqReady,
    output logic rspValid,
    output logic rspWrite,
    output logic rspTimeout,
    output logic [amst_pkg::DATA_W-1:0] rspReadData,
    output logic [amst_pkg::WAIT_UNIT_W-1:0] extraWaitCount,
    input wire logic [PW-1:0] turnaroundCycles,
    input wire logic [PW-1:0] readSetup,
    input wire logic [PW-1:0] readStrobe,
    input wire logic [PW-1:0] readHold,
    input wire logic [PW-1:0] writeSetup,
    input wire logic [PW-1:0] writeStrobe,
    input wire logic [PW-1:0] writeHold,
    input wire logic extendedWaitEnable,
    input wire logic strobeSelectMode,
    input wire logic [amst_pkg::WAIT_LIMIT_W-1:0] maxWaitLimit,
    output logic [amst_pkg::CS_W-1:0] chipSelectN,
    output logic outputEnableN,
    output logic writeEnableN,
    output logic [amst_pkg::BANK_W-1:0] bankAddress,
    output logic [amst_pkg::ADDR_W-1:0] memAddress,
    output logic [amst_pkg::DATA_W-1:0] memDataOut,
    output logic memDataOe,
    input wire logic [amst_pkg::DATA_W-1:0] memDataIn,
    input wire logic waitInput
);
    import amst_pkg::*;
    amst_state_t state_q;
    amst_state_t state_d;
    logic write_q;
    logic [CS_SEL_W-1:0] chip_q;
    logic timeout_q;
    logic [WAIT_UNIT_W-1:0] waitUnits_q;
    logic wait1_q;
    logic wait2_q;
    logic [DATA_W-1:0] data1_q;
    logic [DATA_W-1:0] data2_q;
    logic [1:0] endPipe_q;
    logic [1:0] endWrite_q;
    logic [1:0] endTimeout_q;
    logic [WAIT_UNIT_W-1:0] endUnits_q;
    logic takeReq;
    logic accWrite;
    logic [CS_SEL_W-1:0] accChip;
    logic [PW-1:0] setupLen;
    logic [PW-1:0] strobeRaw;
    logic [PW-1:0] strobeLen;
    logic [PW-1:0] holdLen;
    amst_state_t afterHold;
    logic [PW-1:0] afterHoldLoad;
    amst_state_t afterStrobe;
    logic [PW-1:0] afterStrobeLoad;
    logic phaseLoad;
    logic [PW-1:0] phaseValue;
    logic phaseLast;
    logic unitLoad;
    logic unitLast;
    logic timeoutHit;
    logic [WAIT_UNIT_W-1:0] waitLimit;
    logic strobeQ;
    logic strobeD;
    logic accessD;
    logic strobeEnd;
    logic csActiveD;
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait1_q <= 1'b0;
            wait2_q <= 1'b0;
            data1_q <= DATA_RESET;
            data2_q <= DATA_RESET;
        end else begin
            wait1_q <= waitInput;
            wait2_q <= wait1_q;
            data1_q <= memDataIn;
            data2_q <= data1_q;
        end
    end
    // ------------------------------------------------------------
    // Phase lengths
    // ------------------------------------------------------------
    assign takeReq = reqValid && reqReady;
    assign accWrite = takeReq ? reqWrite : write_q;
    assign accChip = takeReq ? reqChip : chip_q;
    assign setupLen = accWrite ? writeSetup : readSetup;
    assign strobeRaw = accWrite ? writeStrobe : readStrobe;
    assign strobeLen = (strobeRaw == '0) ? PW'(1) : strobeRaw;
    assign holdLen = accWrite ? writeHold : readHold;
    assign waitLimit = WAIT_UNIT_W'({1'b0, maxWaitLimit} + 9'h001);
    assign timeoutHit = unitLast && ((waitUnits_q + 9'h001) == waitLimit);
    assign afterHold = (turnaroundCycles != '0) ? ST_TURN : ST_IDLE;
    assign afterHoldLoad = turnaroundCycles;
    assign afterStrobe = (holdLen != '0) ? ST_HOLD : afterHold;
    assign afterStrobeLoad = (holdLen != '0) ? holdLen : afterHoldLoad;
    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        phaseLoad = 1'b0;
        phaseValue = '0;
        case (state_q)
            ST_IDLE: begin
                if (takeReq) begin
                    phaseLoad = 1'b1;
                    if (setupLen != '0) begin
                        state_d = ST_SETUP;
                        phaseValue = setupLen;
                    end else begin
                        state_d = ST_STROBE;
                        phaseValue = strobeLen;
                    end
                end
            end
            ST_SETUP: begin
                if (phaseLast) begin
                    state_d = ST_STROBE;
                    phaseLoad = 1'b1;
                    phaseValue = strobeLen;
                end
            end
            ST_STROBE: begin
                if (phaseLast) begin
                    if (extendedWaitEnable && wait2_q) begin
                        state_d = ST_EXTEND;
                    end else begin
                        state_d = afterStrobe;
                        phaseLoad = 1'b1;
                        phaseValue = afterStrobeLoad;
                    end
                end
            end
            ST_EXTEND: begin
                if (timeoutHit) begin
                    state_d = afterStrobe;
                    phaseLoad = 1'b1;
                    phaseValue = afterStrobeLoad;
                end else if (!wait2_q) begin
                    state_d = ST_RELEASE;
                    phaseLoad = 1'b1;
                    phaseValue = PW'(RELEASE_LEFT_CYCLES - 1);
                end
            end
            ST_RELEASE: begin
                if (phaseLast) begin
                    state_d = afterStrobe;
                    phaseLoad = 1'b1;
                    phaseValue = afterStrobeLoad;
                end
            end
            ST_HOLD: begin
                if (phaseLast) begin
                    state_d = afterHold;
                    phaseLoad = 1'b1;
                    phaseValue = afterHoldLoad;
                end
            end
            ST_TURN: begin
                if (phaseLast) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end
    // ------------------------------------------------------------
    // Phase and wait unit counters
    // ------------------------------------------------------------
    amst_phase_counter #(.WIDTH(PW)) phaseCounter (
        .clk(clk),
        .reset_n(reset_n),
        .load(phaseLoad),
        .loadValue(phaseValue),
        .last(phaseLast)
    );
    assign unitLoad = (state_q == ST_STROBE && state_d == ST_EXTEND) ||
                      (state_q == ST_EXTEND && unitLast);
    amst_phase_counter #(.WIDTH(UNIT_CNT_W)) unitCounter (
        .clk(clk),
        .reset_n(reset_n),
        .load(unitLoad),
        .loadValue(UNIT_CNT_W'(WAIT_UNIT_CYCLES)),
        .last(unitLast)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            waitUnits_q <= '0;
        end else if (takeReq) begin
            waitUnits_q <= '0;
        end else if (state_q == ST_EXTEND && unitLast) begin
            waitUnits_q <= waitUnits_q + 9'h001;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timeout_q <= 1'b0;
        end else if (takeReq) begin
            timeout_q <= 1'b0;
        end else if (state_q == ST_EXTEND && timeoutHit) begin
            timeout_q <= 1'b1;
        end
    end
    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            write_q <= 1'b0;
            chip_q <= '0;
            memAddress <= ADDR_RESET;
            bankAddress <= BANK_RESET;
            memDataOut <= DATA_RESET;
        end else if (takeReq) begin
            write_q <= reqWrite;
            chip_q <= reqChip;
            memAddress <= reqAddress;
            bankAddress <= reqBank;
            memDataOut <= reqWriteData;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reqReady <= 1'b1;
        end else begin
            reqReady <= (state_d == ST_IDLE);
        end
    end
    // ------------------------------------------------------------
    // Memory strobes
    // ------------------------------------------------------------
    assign strobeQ = (state_q == ST_STROBE) || (state_q == ST_EXTEND) ||
                     (state_q == ST_RELEASE);
    assign strobeD = (state_d == ST_STROBE) || (state_d == ST_EXTEND) ||
                     (state_d == ST_RELEASE);
    assign accessD = (state_d != ST_IDLE) && (state_d != ST_TURN);
    assign csActiveD = strobeSelectMode ? strobeD : accessD;
    assign strobeEnd = strobeQ && !strobeD;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            chipSelectN <= CS_IDLE;
            outputEnableN <= STROBE_IDLE;
            writeEnableN <= STROBE_IDLE;
            memDataOe <= 1'b0;
        end else begin
            chipSelectN <= csActiveD ? ~(CS_ONE_HOT_BASE << accChip) : CS_IDLE;
            outputEnableN <= !(strobeD && !accWrite);
            writeEnableN <= !(strobeD && accWrite);
            memDataOe <= accessD && accWrite;
        end
    end
    // ------------------------------------------------------------
    // Completion and read data
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            endPipe_q <= 2'h0;
            endWrite_q <= 2'h0;
            endTimeout_q <= 2'h0;
            endUnits_q <= '0;
        end else begin
            endPipe_q <= {endPipe_q[0], strobeEnd};
            endWrite_q <= {endWrite_q[0], write_q};
            endTimeout_q <= {endTimeout_q[0], timeout_q || (state_q == ST_EXTEND && timeoutHit)};
            endUnits_q <= endPipe_q[0] ? waitUnits_q : endUnits_q;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rspValid <= 1'b0;
            rspWrite <= 1'b0;
            rspTimeout <= 1'b0;
            rspReadData <= DATA_RESET;
            extraWaitCount <= '0;
        end else begin
            rspValid <= endPipe_q[1];
            if (endPipe_q[1]) begin
                rspWrite <= endWrite_q[1];
                rspTimeout <= endTimeout_q[1];
                extraWaitCount <= endUnits_q;
                if (!endWrite_q[1]) begin
                    rspReadData <= data2_q;
                end
            end
        end
    end
endmodule

// ==== dv/amst_mem_model.sv ====
// Behavioural asynchronous memory with a wait output
`timescale 1ns/1ps
module amst_mem_model
    import amst_pkg::*;
(
    input logic clk,
    input logic reset_n,
    input logic [amst_pkg::CS_W-1:0] chipSelectN,
    input logic outputEnableN,
    input logic writeEnableN,
    input logic [amst_pkg::ADDR_W-1:0] memAddress,
    input logic [amst_pkg::DATA_W-1:0] memDataOut,
    input logic memDataOe,
    input int waitLen,
    output logic [amst_pkg::DATA_W-1:0] memDataIn,
    output logic waitInput
);
    logic [DATA_W-1:0] mem [0:255];
    logic [DATA_W-1:0] last_q;
    logic strobe;
    logic strobe_q;
    logic selected;
    int waitLeft_q;
    assign selected = chipSelectN != CS_IDLE;
    assign strobe = !outputEnableN || !writeEnableN;
    assign waitInput = waitLeft_q > 0;
    always_comb begin
        if (memDataOe)
            memDataIn = memDataOut;
        else if (selected && !outputEnableN)
            memDataIn = mem[memAddress[7:0]];
        else
            memDataIn = ~last_q;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            last_q <= 16'h0000;
            strobe_q <= 1'b0;
            waitLeft_q <= 0;
        end else begin
            last_q <= memDataIn;
            strobe_q <= strobe;
            if (selected && !writeEnableN)
                mem[memAddress[7:0]] <= memDataOut;
            if (strobe && !strobe_q && waitLen > 0)
                waitLeft_q <= waitLen;
            else if (waitLeft_q > 0)
                waitLeft_q <= waitLeft_q - 1;
        end
    end
endmodule

// ==== dv/amst_strobe_timing_assertions.sv ====
// Concurrent checks on the strobe sequencer ports
`timescale 1ns/1ps
module amst_strobe_timing_assertions
    import amst_pkg::*;
#(
    parameter int PW = amst_pkg::PHASE_W
) (
    input logic clk,
    input logic reset_n,
    input logic reqReady,
    input logic rspValid,
    input logic rspTimeout,
    input logic [amst_pkg::WAIT_UNIT_W-1:0] extraWaitCount,
    input logic [PW-1:0] readSetup,
    input logic [PW-1:0] readStrobe,
    input logic [PW-1:0] readHold,
    input logic [PW-1:0] writeSetup,
    input logic [PW-1:0] writeStrobe,
    input logic [PW-1:0] writeHold,
    input logic extendedWaitEnable,
    input logic strobeSelectMode,
    input logic [amst_pkg::WAIT_LIMIT_W-1:0] maxWaitLimit,
    input logic [amst_pkg::CS_W-1:0] chipSelectN,
    input logic outputEnableN,
    input logic writeEnableN,
    input logic memDataOe,
    input logic waitInput
);
    logic csIdle;
    logic [PW-1:0] oeLow_q;
    logic [PW-1:0] weLow_q;
    logic [PW-1:0] csOnly_q;
    logic lastRd_q;
    assign csIdle = chipSelectN == CS_IDLE;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oeLow_q <= '0;
            weLow_q <= '0;
            csOnly_q <= '0;
            lastRd_q <= 1'b0;
        end else begin
            oeLow_q <= outputEnableN ? '0 : oeLow_q + 1'b1;
            weLow_q <= writeEnableN ? '0 : weLow_q + 1'b1;
            csOnly_q <= (csIdle || !outputEnableN || !writeEnableN) ? '0 : csOnly_q + 1'b1;
            lastRd_q <= !outputEnableN ? 1'b1 : (!writeEnableN ? 1'b0 : lastRd_q);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_wait_gone;
        extendedWaitEnable && $fell(waitInput);
    endsequence
    sequence s_rd_end;
        ##4 $rose(outputEnableN);
    endsequence
    sequence s_wr_end;
        ##[3:4] $rose(writeEnableN);
    endsequence
    a_idle_all_high:
        assert property (reqReady |-> csIdle && outputEnableN && writeEnableN)
        else $error("Strobe active while idle");
    a_rd_strobe_width:
        assert property ($rose(outputEnableN) && !extendedWaitEnable
            |-> oeLow_q == readStrobe + PW'(readStrobe == 0))
        else $error("Read strobe width wrong");
    a_wr_strobe_width:
        assert property ($rose(writeEnableN) && !extendedWaitEnable
            |-> weLow_q == writeStrobe + PW'(writeStrobe == 0))
        else $error("Write strobe width wrong");
    a_rd_setup_lead:
        assert property ($fell(outputEnableN) && !strobeSelectMode |-> csOnly_q == readSetup)
        else $error("Read setup length wrong");
    a_wr_setup_lead:
        assert property ($fell(writeEnableN) && !strobeSelectMode |-> csOnly_q == writeSetup)
        else $error("Write setup length wrong");
    a_hold_tail_len:
        assert property ($rose(csIdle) && !strobeSelectMode
            |-> csOnly_q == (lastRd_q ? readHold : writeHold))
        else $error("Hold length wrong");
    a_select_follows:
        assert property (strobeSelectMode |-> !csIdle == (!outputEnableN || !writeEnableN))
        else $error("Select not aligned to strobe");
    a_rd_wait_release:
        assert property (s_wait_gone ##0 !outputEnableN |-> s_rd_end)
        else $error("Read strobe release late or early");
    a_wr_wait_release:
        assert property (s_wait_gone ##0 !writeEnableN |-> s_wr_end)
        else $error("Write strobe release late or early");
    a_timeout_units:
        assert property (rspValid && rspTimeout |-> extraWaitCount == {1'b0, maxWaitLimit} + 9'h001)
        else $error("Timeout unit count wrong");
    a_units_in_limit:
        assert property (rspValid && !rspTimeout |-> extraWaitCount <= {1'b0, maxWaitLimit})
        else $error("Unit count above limit");
    a_no_wait_units:
        assert property (rspValid && !extendedWaitEnable |-> extraWaitCount == 9'h000)
        else $error("Units counted with wait off");
    a_data_drive_on:
        assert property (!writeEnableN |-> memDataOe)
        else $error("Data bus not driven during write strobe");
endmodule
bind amst_strobe_timing amst_strobe_timing_assertions #(.PW(PW)) amst_strobe_timing_assertions_i (
    .clk, .reset_n, .reqReady, .rspValid, .rspTimeout, .extraWaitCount,
    .readSetup, .readStrobe, .readHold, .writeSetup, .writeStrobe, .writeHold,
    .extendedWaitEnable, .strobeSelectMode, .maxWaitLimit, .chipSelectN,
    .outputEnableN, .writeEnableN, .waitInput, .memDataOe
);

// ==== dv/tb_amst_strobe_timing.sv ====
// Self-checking bench for the strobe sequencer
`timescale 1ns/1ps
module tb_amst_strobe_timing;
    import amst_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic [ADDR_W-1:0] reqAddress = '0;
    logic [BANK_W-1:0] reqBank = '0;
    logic [CS_SEL_W-1:0] reqChip = '0;
    logic [DATA_W-1:0] reqWriteData = '0;
    logic [PHASE_W-1:0] turnaroundCycles = '0, readSetup = '0, readStrobe = 8'h01;
    logic [PHASE_W-1:0] readHold = '0, writeSetup = '0, writeStrobe = 8'h01, writeHold = '0;
    logic extendedWaitEnable = 1'b0, strobeSelectMode = 1'b0;
    logic [WAIT_LIMIT_W-1:0] maxWaitLimit = 8'hFF;
    logic reqReady, rspValid, rspWrite, rspTimeout, outputEnableN, writeEnableN;
    logic memDataOe, waitInput;
    logic [DATA_W-1:0] rspReadData, memDataOut, memDataIn, rData;
    logic [WAIT_UNIT_W-1:0] extraWaitCount, rCnt;
    logic [CS_W-1:0] chipSelectN;
    logic [BANK_W-1:0] bankAddress;
    logic [ADDR_W-1:0] memAddress;
    logic rTo, rWr;
    int waitLen = 0;
    int bad_count = 0, total_checks = 0, csLo, stLo, turn, rspAt;
    always #5 clk = ~clk;
    amst_strobe_timing amst_strobe_timing_i (.clk, .reset_n, .reqValid, .reqWrite, .reqAddress,
        .reqBank, .reqChip, .reqWriteData, .reqReady, .rspValid, .rspWrite, .rspTimeout,
        .rspReadData, .extraWaitCount, .turnaroundCycles, .readSetup, .readStrobe, .readHold,
        .writeSetup, .writeStrobe, .writeHold, .extendedWaitEnable, .strobeSelectMode,
        .maxWaitLimit, .chipSelectN, .outputEnableN, .writeEnableN, .bankAddress, .memAddress,
        .memDataOut, .memDataOe, .memDataIn, .waitInput);
    amst_mem_model amst_mem_model_i (.clk, .reset_n, .chipSelectN, .outputEnableN,
        .writeEnableN, .memAddress, .memDataOut, .memDataOe, .waitLen, .memDataIn, .waitInput);
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("Checks %0d, errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic cfg(input logic [7:0] ta, rs, rst, rh, ws, write_strobe, wh, input logic ew, ss,
        input logic [7:0] mw);
        turnaroundCycles = ta;
        readSetup = rs;
        readStrobe = rst;
        readHold = rh;
        writeSetup = ws;
        writeStrobe = write_strobe;
        writeHold = wh;
        extendedWaitEnable = ew;
        strobeSelectMode = ss;
        maxWaitLimit = mw;
    endtask
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int k;
        k = 0;
        reqValid = 1'b1;
        reqWrite = wr;
        reqAddress = a;
        reqWriteData = d;
        reqBank = a[1:0];
        reqChip = a[3:2];
        while (reqReady !== 1'b1 && k < 100) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (reqReady !== 1'b1) begin
            chk("request wait", 1, reqReady);
            finish_test();
        end
        @(posedge clk);
        #1;
        reqValid = 1'b0;
        csLo = 0;
        stLo = 0;
        turn = 0;
        rspAt = 0;
        k = 0;
        while ((reqReady !== 1'b1 || rspAt == 0) && k < 2000) begin
            k++;
            if (chipSelectN !== CS_IDLE)
                csLo++;
            if (outputEnableN === 1'b0 || writeEnableN === 1'b0)
                stLo++;
            if (chipSelectN === CS_IDLE && stLo > 0 && reqReady !== 1'b1)
                turn++;
            if (rspValid === 1'b1) begin
                rspAt = k;
                rData = rspReadData;
                rCnt = extraWaitCount;
                rTo = rspTimeout;
                rWr = rspWrite;
            end
            @(posedge clk);
            #1;
        end
        if (reqReady !== 1'b1 || rspAt == 0) begin
            chk("access done", 1, 0);
            finish_test();
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_plain();
        cfg(2, 2, 3, 1, 1, 4, 2, 0, 0, 8'hFF);
        access(1'b1, 21'h000015, 16'hA55A);
        chk("write cycle", 7, csLo);
        chk("write strobe", 4, stLo);
        chk("turnaround", 2, turn);
        chk("write answer", 8, rspAt);
        chk("write kind", 1, rWr);
        chk("bank address", 2'h1, bankAddress);
        chk("mem address", 21'h000015, memAddress);
        access(1'b0, 21'h000015, 16'h0000);
        chk("read cycle", 6, csLo);
        chk("read strobe", 3, stLo);
        chk("read answer", 8, rspAt);
        chk("read data", 16'hA55A, rData);
        chk("read kind", 0, rWr);
    endtask
    task automatic t_zero();
        cfg(0, 0, 3, 0, 0, 2, 0, 0, 0, 8'hFF);
        access(1'b1, 21'h00002A, 16'h3C3C);
        chk("zero write cycle", 2, csLo);
        chk("zero turnaround", 0, turn);
        access(1'b0, 21'h00002A, 16'h0000);
        chk("zero read cycle", 3, csLo);
        chk("zero read answer", 6, rspAt);
        chk("zero read data", 16'h3C3C, rData);
    endtask
    task automatic t_select();
        cfg(1, 2, 3, 2, 2, 3, 2, 0, 1, 8'hFF);
        access(1'b0, 21'h000015, 16'h0000);
        chk("select read cs", 3, csLo);
        chk("select read data", 16'hA55A, rData);
        access(1'b1, 21'h000016, 16'h0F0F);
        chk("select write cs", 3, csLo);
    endtask
    task automatic t_wait();
        cfg(1, 1, 6, 1, 1, 6, 1, 1, 0, 8'hFF);
        waitLen = 40;
        for (int i = 1; i >= 0; i--) begin
            access(i[0], 21'h000033, 16'h5AA5);
            chk("wait strobe", waitLen + 1 + WAIT_RELEASE_CYCLES, stLo);
            chk("wait units", (stLo - 6) / 16, rCnt);
            chk("wait cycle", stLo + 2, csLo);
            chk("wait no timeout", 0, rTo);
        end
        chk("wait read data", 16'h5AA5, rData);
        waitLen = 0;
    endtask
    task automatic t_timeout();
        int k;
        for (int lim = 0; lim < 2; lim++) begin
            cfg(1, 1, 6, 1, 1, 6, 1, 1, 0, lim[7:0]);
            waitLen = 90;
            access(1'b0, 21'h000033, 16'h0000);
            chk("timeout flag", 1, rTo);
            chk("timeout units", lim + 1, rCnt);
            waitLen = 0;
            k = 0;
            while (waitInput !== 1'b0 && k < 200) begin
                @(posedge clk);
                #1;
                k++;
            end
            chk("wait released", 0, waitInput);
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        #1;
        reset_n = 1'b1;
        @(posedge clk);
        #1;
        t_plain();
        t_zero();
        t_select();
        t_wait();
        t_timeout();
        finish_test();
    end
endmodule
